// ==== hw/host_command_decoder.sv ====
// host command decoder: checks command strings and dispatches actions
// Overview of operation
// - a command ends at the first zero byte
// - fields sit at fixed positions with no separators
// - each template letter is exactly one character
// - numeric fields are parsed as hexadecimal
// - bank letter L picks ports 0-15, H picks 16-31
// - stream 00-1f, timeslot 00-7f, two hex digits each
// - tone digit 0-b: dial, reorder, busy, ringback, milliwatt, silence, variants
// - dial strings allow 0-9 * # A-D U L X P
// - companding letter M gives mu-law, A gives A-law
// - line power per port: F off, N on, star unchanged
// - protocol per port: 2, 3, or switch variant A D E N
// - role per port: N network, T terminal, U unused, star unchanged
// - fixed id 0-3f, packet id 0-7e
// - id removal on network ports only, 7f removes all
// - one command enables host interrupts and messages, another disables
// - processor message passes only the selector's low four bits
// - global reset clears line power and host interrupt enable and also resets the processor, processor reset only the processor
// - physical deactivate and reactivate only on network ports
// - firmware load 1K at four-digit address, erase and copy segment
// - commands hold at most 32 characters
`timescale 1ns/1ps
`include "cmd_dec_cfg.svh"
module host_command_decoder
  import cmd_dec_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic char_valid,
  input wire logic [7:0] char_data,
  output logic cmd_valid,
  output op_e cmd_op,
  output result_e cmd_result,
  output logic [7:0] arg_a,
  output logic [7:0] arg_b,
  output logic [15:0] arg_c,
  output logic [7:0] proc_msg_sel,
  output logic mu_law,
  output logic host_irq_en,
  output logic [31:0] line_power,
  output logic [63:0] port_role,
  output logic [127:0] port_protocol,
  output logic global_reset_pulse,
  output logic proc_reset_pulse
);
  cmd_fields_if f();
  cmd_collect u_collect (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ce(ce),
    .char_valid(char_valid),
    .char_data(char_data),
    .f(f)
  );

  // one hex character to a nibble; bit 4 flags a non-hex character
  function automatic logic [4:0] hex_nib(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) return {1'b0, c[3:0]};
    if (c >= 8'h41 && c <= 8'h46) return {1'b0, c[3:0] + 4'h9};
    return 5'h10;
  endfunction

  // two hex characters to a byte; bit 8 flags a bad digit
  function automatic logic [8:0] hex_byte(input logic [7:0] hi, input logic [7:0] lo);
    logic [4:0] h;
    logic [4:0] l;
    h = hex_nib(hi);
    l = hex_nib(lo);
    return {h[4] | l[4], h[3:0], l[3:0]};
  endfunction

  // bank letter to base port; bit 5 flags a bad letter
  function automatic logic [5:0] bank_base(input logic [7:0] c);
    if (c == "L") return 6'd0;
    if (c == "H") return 6'd16;
    return 6'h20;
  endfunction

  // valid dial string character
  function automatic logic dial_ok(input logic [7:0] c);
    return (c >= "0" && c <= "9") || c == "*" || c == "#" || (c >= "A" && c <= "D") ||
      c == "U" || c == "L" || c == "X" || c == "P";
  endfunction

  // per-port code tables
  function automatic logic power_ok(input logic [7:0] c);
    return c == "F" || c == "N" || c == "*";
  endfunction
  function automatic logic proto_ok(input logic [7:0] c);
    return c == "2" || c == "3" || c == "A" || c == "D" || c == "E" || c == "N";
  endfunction
  function automatic logic role_ok(input logic [7:0] c);
    return c == "N" || c == "T" || c == "U" || c == "*";
  endfunction
  function automatic logic [3:0] proto_code(input logic [7:0] c);
    unique case (c)
      "2": return 4'h2;
      "3": return 4'h3;
      "A": return 4'ha;
      "D": return 4'hd;
      "E": return 4'he;
      default: return 4'h5;
    endcase
  endfunction

  logic [7:0] c0, c1, c2, c3, c4, c5, c6, c7;
  logic [5:0] len;
  logic [8:0] b23, b45, b67, b12, b34;
  logic [4:0] n2, n4;
  logic [5:0] bank;
  logic [15:0] chk_pow, chk_pro, chk_role;
  logic [31:4] chk_dial;
  logic [4:0] port_n;
  op_e next_op;
  result_e next_res;
  logic [7:0] next_a, next_b;
  logic [15:0] next_c;

  assign c0 = f.chr[0];
  assign c1 = f.chr[1];
  assign c2 = f.chr[2];
  assign c3 = f.chr[3];
  assign c4 = f.chr[4];
  assign c5 = f.chr[5];
  assign c6 = f.chr[6];
  assign c7 = f.chr[7];
  assign len = f.len;
  assign b23 = hex_byte(c2, c3);
  assign b45 = hex_byte(c4, c5);
  assign b67 = hex_byte(c6, c7);
  assign b12 = hex_byte(c1, c2);
  assign b34 = hex_byte(c3, c4);
  assign n2 = hex_nib(c2);
  assign n4 = hex_nib(c4);
  assign bank = bank_base(c2);
  assign port_n = b23[4:0];

  // per-character checks over the 16-port field
  genvar g;
  generate
    for (g = 0; g < `BANK_PORTS; g++) begin : g_chk
      assign chk_pow[g] = power_ok(f.chr[3 + g]);
      assign chk_pro[g] = proto_ok(f.chr[3 + g]);
      assign chk_role[g] = role_ok(f.chr[3 + g]);
    end
    // dial digits may fill the buffer up to its last character
    for (g = 4; g < `CMD_MAX_LEN; g++) begin : g_dial
      assign chk_dial[g] = (g >= len) || dial_ok(f.chr[g]);
    end
  endgenerate

  // network-side test on the addressed port
  logic port_is_net;
  assign port_is_net = port_role[{port_n, 1'b0} +: 2] == `ROLE_NET;

  // decode prefix and check every parameter except the processor message fields
  always_comb begin
    next_op = op_none;
    next_res = res_bad_param;
    next_a = 8'h00;
    next_b = 8'h00;
    next_c = 16'h0000;
    if (f.overflow) begin
      next_res = res_bad_param;
    end else if (c0 == "C" && c1 == "P") begin
      next_op = op_tone;
      next_a = b23[7:0];
      next_b = {4'h0, n4[3:0]};
      if (len == 6'd5 && !b23[8] && b23[7:0] <= `CHAN_MAX && !n4[4] &&
          n4[3:0] <= `TONE_MAX) next_res = res_ok;
    end else if (c0 == "C" && c1 == "S") begin
      next_op = op_tone_slot;
      next_a = b23[7:0];
      next_b = b67[7:0];
      next_c = {b45[7:0], b67[7:0]};
      if (len == 6'd8 && !b23[8] && !b45[8] && !b67[8] && b45[7:0] <= `STREAM_MAX &&
          b67[7:0] <= `SLOT_MAX && b23[7:0] <= `CHAN_MAX) next_res = res_ok;
    end else if (c0 == "C" && c1 == "T") begin
      next_op = op_dial;
      next_a = b23[7:0];
      next_b = {2'b00, len - 6'd4};
      if (len >= 6'd5 && !b23[8] && b23[7:0] <= `CHAN_MAX && &chk_dial) next_res = res_ok;
    end else if (c0 == "S" && c1 == "E") begin
      next_op = op_companding;
      if (len == 6'd3 && (c2 == "M" || c2 == "A")) next_res = res_ok;
    end else if (c0 == "S" && (c1 == "F" || c1 == "L" || c1 == "T")) begin
      next_op = c1 == "F" ? op_line_power : (c1 == "L" ? op_protocol : op_port_role);
      next_a = {2'b00, bank};
      if (len == 6'd19 && !bank[5] && (c1 == "F" ? &chk_pow : (c1 == "L" ? &chk_pro :
          &chk_role))) next_res = res_ok;
    end else if (c0 == "T" && (c1 == "F" || c1 == "P" || c1 == "R")) begin
      next_op = c1 == "F" ? op_fixed_id : (c1 == "P" ? op_packet_id : op_id_remove);
      next_a = b23[7:0];
      next_b = b45[7:0];
      if (len == 6'd6 && !b23[8] && !b45[8] && b23[7:0] <= `PORT_MAX &&
          b45[7:0] <= (c1 == "F" ? `FIXED_ID_MAX : (c1 == "P" ? `PACKET_ID_MAX :
          `REMOVE_ALL_ID)) && (c1 != "R" || port_is_net)) next_res = res_ok;
    end else if (c0 == "I" && (c1 == "N" || c1 == "F")) begin
      next_op = c1 == "N" ? op_irq_on : op_irq_off;
      if (len == 6'd2) next_res = res_ok;
    end else if (c0 == "Q" && c1 == "P") begin
      next_op = op_proc_msg;
      next_a = {4'h0, c2[3:0]};
      next_b = {4'h0, c3[3:0]};
      if (len >= 6'd4) next_res = res_ok;
    end else if (c0 == "R" && (c1 == "A" || c1 == "D")) begin
      next_op = c1 == "A" ? op_global_reset : op_proc_reset;
      if (len == 6'd2) next_res = res_ok;
    end else if (c0 == "R" && (c1 == "I" || c1 == "L")) begin
      next_op = c1 == "I" ? op_phy_deact : op_phy_react;
      next_a = b23[7:0];
      if (len == 6'd4 && !b23[8] && b23[7:0] <= `PORT_MAX && port_is_net)
        next_res = res_ok;
    end else if (c0 == "@" && (c1 == "E" || c1 == "W") && len == 6'd3) begin
      next_op = c1 == "E" ? op_fw_erase : op_fw_copy;
      next_a = {3'b000, n2};
      if (!n2[4]) next_res = res_ok;
    end else if (c0 == "@") begin
      next_op = op_fw_load;
      next_c = {b12[7:0], b34[7:0]};
      if (len == 6'd5 && !b12[8] && !b34[8]) next_res = res_ok;
    end else begin
      next_res = res_bad_prefix;
    end
  end

  // result strobe and dispatched arguments
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cmd_valid <= 1'b0;
      cmd_op <= op_none;
      cmd_result <= res_ok;
      arg_a <= 8'h00;
      arg_b <= 8'h00;
      arg_c <= 16'h0000;
      proc_msg_sel <= 8'h00;
      global_reset_pulse <= 1'b0;
      proc_reset_pulse <= 1'b0;
    end else if (ce) begin
      cmd_valid <= f.done;
      global_reset_pulse <= f.done && next_res == res_ok && next_op == op_global_reset;
      proc_reset_pulse <= f.done && next_res == res_ok &&
        (next_op == op_proc_reset || next_op == op_global_reset);
      if (f.done) begin
        cmd_op <= next_op;
        cmd_result <= next_res;
        arg_a <= next_a;
        arg_b <= next_b;
        arg_c <= next_c;
        if (next_res == res_ok && next_op == op_proc_msg) proc_msg_sel <= next_b;
      end
    end
  end

  // configuration state, written only by accepted commands
  logic accept;
  assign accept = f.done && next_res == res_ok;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mu_law <= 1'b1;
      host_irq_en <= 1'b0;
    end else if (ce && accept) begin
      if (next_op == op_companding) mu_law <= c2 == "M";
      if (next_op == op_irq_on) host_irq_en <= 1'b1;
      if (next_op == op_irq_off || next_op == op_global_reset) host_irq_en <= 1'b0;
    end
  end

  // per-port tables for the selected bank
  for (g = 0; g < `BANK_PORTS; g++) begin : g_port
    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        line_power[g] <= 1'b0;
        line_power[g + 16] <= 1'b0;
        port_role[2*g +: 2] <= `ROLE_UNUSED;
        port_role[2*g + 32 +: 2] <= `ROLE_UNUSED;
        port_protocol[4*g +: 4] <= 4'h3;
        port_protocol[4*g + 64 +: 4] <= 4'h3;
      end else if (ce && accept) begin
        if (next_op == op_global_reset) begin
          line_power[g] <= 1'b0;
          line_power[g + 16] <= 1'b0;
        end
        if (next_op == op_line_power && f.chr[3 + g] != "*") begin
          if (bank[4]) line_power[g + 16] <= f.chr[3 + g] == "N";
          else line_power[g] <= f.chr[3 + g] == "N";
        end
        if (next_op == op_port_role && f.chr[3 + g] != "*") begin
          if (bank[4]) port_role[2*g + 32 +: 2] <= f.chr[3 + g] == "N" ? `ROLE_NET :
            (f.chr[3 + g] == "T" ? `ROLE_TERM : `ROLE_UNUSED);
          else port_role[2*g +: 2] <= f.chr[3 + g] == "N" ? `ROLE_NET :
            (f.chr[3 + g] == "T" ? `ROLE_TERM : `ROLE_UNUSED);
        end
        if (next_op == op_protocol) begin
          if (bank[4]) port_protocol[4*g + 64 +: 4] <= proto_code(f.chr[3 + g]);
          else port_protocol[4*g +: 4] <= proto_code(f.chr[3 + g]);
        end
      end
    end
  end
endmodule

// ==== hw/cmd_dec_cfg.svh ====
// constants for the host command decoder
`ifndef CMD_DEC_CFG_SVH
`define CMD_DEC_CFG_SVH
`define CMD_MAX_LEN 6'd32
`define CMD_NUL 8'h00
`define STREAM_MAX 8'h1f
`define SLOT_MAX 8'h7f
`define TONE_SLOT_LO 8'h20
`define TONE_SLOT_HI 8'h25
`define TONE_MAX 4'hb
`define FIXED_ID_MAX 8'h3f
`define PACKET_ID_MAX 8'h7e
`define REMOVE_ALL_ID 8'h7f
`define BANK_PORTS 16
`define PORT_MAX 8'h1f
`define CHAN_MAX 8'h3f
`define ROLE_UNUSED 2'd0
`define ROLE_NET 2'd1
`define ROLE_TERM 2'd2
`endif

// ==== hw/cmd_dec_pkg.sv ====
// types for the host command decoder
package cmd_dec_pkg;
  typedef enum logic [4:0] {
    op_none, op_tone, op_tone_slot, op_dial, op_companding, op_line_power, op_protocol,
    op_port_role, op_fixed_id, op_packet_id, op_id_remove, op_irq_on, op_irq_off,
    op_proc_msg, op_global_reset, op_proc_reset, op_phy_deact, op_phy_react,
    op_fw_load, op_fw_erase, op_fw_copy
  } op_e;
  typedef enum logic [1:0] {res_ok, res_bad_prefix, res_bad_param} result_e;
endpackage

// ==== hw/cmd_fields_if.sv ====
// parsed command buffer shared between collector and decoder
`timescale 1ns/1ps
interface cmd_fields_if;
  logic [7:0] chr [0:31];
  logic [5:0] len;
  logic done;
  logic overflow;
  modport src (output chr, output len, output done, output overflow);
  modport dst (input chr, input len, input done, input overflow);
endinterface

// ==== hw/cmd_collect.sv ====
// collects command characters until the zero byte
`timescale 1ns/1ps
`include "cmd_dec_cfg.svh"
module cmd_collect (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic char_valid,
  input wire logic [7:0] char_data,
  cmd_fields_if.src f
);
  logic [5:0] cnt;
  logic ovf;
  // storage of characters by index
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 32; i++) f.chr[i] <= 8'h00;
    end else if (ce && char_valid && char_data != `CMD_NUL && cnt < `CMD_MAX_LEN) begin
      f.chr[cnt[4:0]] <= char_data;
    end
  end
  // count, length and end-of-command pulse
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 6'd0;
      ovf <= 1'b0;
      f.len <= 6'd0;
      f.done <= 1'b0;
      f.overflow <= 1'b0;
    end else if (ce) begin
      f.done <= 1'b0;
      if (char_valid) begin
        if (char_data == `CMD_NUL) begin
          f.len <= cnt;
          f.overflow <= ovf;
          f.done <= 1'b1;
          cnt <= 6'd0;
          ovf <= 1'b0;
        end else if (cnt < `CMD_MAX_LEN) begin
          cnt <= cnt + 6'd1;
        end else begin
          ovf <= 1'b1;
        end
      end
    end
  end
endmodule

// ==== dv/host_command_decoder_properties.sv ====
// port assertions for the host command decoder
`timescale 1ns/1ps
module host_command_decoder_check
  import cmd_dec_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic char_valid,
  input wire logic [7:0] char_data,
  input wire logic cmd_valid,
  input wire op_e cmd_op,
  input wire result_e cmd_result,
  input wire logic mu_law,
  input wire logic host_irq_en,
  input wire logic [31:0] line_power,
  input wire logic [63:0] port_role,
  input wire logic [127:0] port_protocol,
  input wire logic global_reset_pulse,
  input wire logic proc_reset_pulse
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // accepted command this cycle
  wire logic ok = cmd_valid && cmd_result == res_ok;
  end_latency_a: assert property (
    (ce && char_valid && char_data == 8'h00) ##1 ce |=> cmd_valid)
    else $error("no decode after terminator");
  pulse_single_a: assert property (cmd_valid && ce |=> !cmd_valid)
    else $error("decode strobe too long");
  reset_pair_a: assert property (
    global_reset_pulse |-> proc_reset_pulse && ok && cmd_op == op_global_reset)
    else $error("global reset pulse without cause");
  proc_only_a: assert property (
    ok && cmd_op == op_proc_reset |-> proc_reset_pulse && !global_reset_pulse)
    else $error("processor reset pulse wrong");
  reject_hold_a: assert property (
    cmd_valid && cmd_result != res_ok |-> $stable(mu_law) && $stable(host_irq_en)
    && $stable(line_power) && $stable(port_role) && $stable(port_protocol))
    else $error("rejected command changed config");
  law_cause_a: assert property ($changed(mu_law) |-> ok && cmd_op == op_companding)
    else $error("companding changed without command");
  irq_level_a: assert property (
    ok && cmd_op inside {op_irq_on, op_irq_off} |-> host_irq_en == (cmd_op == op_irq_on))
    else $error("irq enable not set by command");
  power_cause_a: assert property (
    $changed(line_power) |-> ok && cmd_op inside {op_line_power, op_global_reset})
    else $error("line power changed without command");
  role_cause_a: assert property (
    $changed(port_role) |-> ok && cmd_op inside {op_port_role, op_global_reset})
    else $error("port role changed without command");
  cover property (ok && cmd_op == op_global_reset);
  cover property (cmd_valid && cmd_result == res_bad_param);
  cover property (cmd_valid && cmd_result == res_bad_prefix);
endmodule

bind host_command_decoder host_command_decoder_check i_check (.clk_sys(clk_sys), .rst_b(rst_b),
  .ce(ce), .char_valid(char_valid), .char_data(char_data), .cmd_valid(cmd_valid),
  .cmd_op(cmd_op), .cmd_result(cmd_result), .mu_law(mu_law), .host_irq_en(host_irq_en),
  .line_power(line_power), .port_role(port_role), .port_protocol(port_protocol),
  .global_reset_pulse(global_reset_pulse), .proc_reset_pulse(proc_reset_pulse));

// ==== dv/host_command_decoder_test.sv ====
// self-checking bench for the host command decoder
`timescale 1ns/1ps
module host_command_decoder_test;
  import cmd_dec_pkg::*;
  typedef struct {op_e op; result_e res; logic mu; logic irq; logic [31:0] lp;
    logic [63:0] role; logic [127:0] prot; logic [7:0] sel;
    logic ca; logic [7:0] aa; logic [7:0] ab; logic [15:0] ac;} note_s;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic char_valid = 1'b0;
  logic [7:0] char_data = 8'h00;
  logic cmd_valid, mu_law, host_irq_en, global_reset_pulse, proc_reset_pulse;
  op_e cmd_op;
  result_e cmd_result;
  logic [7:0] proc_msg_sel;
  logic [7:0] arg_a;
  logic [7:0] arg_b;
  logic [15:0] arg_c;
  logic cv_seen = 1'b0;
  logic [31:0] line_power;
  logic [63:0] port_role;
  logic [127:0] port_protocol;
  int err_count = 0;
  int cmp_count = 0;
  logic [31:0] rng = 32'h5dc2;
  note_s m;
  note_s n;
  note_s q[$];
  string s;
  string al;
  byte c;

  host_command_decoder i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce),
    .char_valid(char_valid), .char_data(char_data), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_result(cmd_result), .arg_a(arg_a), .arg_b(arg_b), .arg_c(arg_c),
    .proc_msg_sel(proc_msg_sel),
    .mu_law(mu_law), .host_irq_en(host_irq_en), .line_power(line_power),
    .port_role(port_role), .port_protocol(port_protocol),
    .global_reset_pulse(global_reset_pulse), .proc_reset_pulse(proc_reset_pulse));

  // 125 MHz clock
  always #4 clk_sys = ~clk_sys;

  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic chk(input logic [127:0] seen, input logic [127:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  task automatic check_cfg(input note_s e);
    chk(mu_law, e.mu, "companding");
    chk(host_irq_en, e.irq, "irq enable");
    chk(line_power, e.lp, "line power");
    chk(port_role, e.role, "port role");
    chk(port_protocol, e.prot, "protocol");
  endtask

  // note the expectation, then feed the string and its terminator
  task automatic send(input string t, input op_e op, input result_e res,
    input logic ca = 1'b0, input logic [7:0] a = 8'h00, input logic [7:0] b = 8'h00,
    input logic [15:0] cw = 16'h0000);
    m.op = op;
    m.res = res;
    m.ca = ca;
    m.aa = a;
    m.ab = b;
    m.ac = cw;
    q.push_back(m);
    for (int i = 0; i <= t.len(); i++) begin
      char_valid = 1'b1;
      char_data = (i < t.len()) ? t[i] : 8'h00;
      @(posedge clk_sys);
      #1;
    end
    repeat (rnd() % 3) begin
      char_valid = 1'b0;
      @(posedge clk_sys);
      #1;
    end
  endtask

  task close_out;
    if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // result watcher: settled outputs, one comparison per strobe even while frozen
  always @(negedge clk_sys) begin
    if (rst_b && cmd_valid === 1'b1 && !cv_seen) begin
      if (q.size() == 0) begin
        chk(1'b1, 1'b0, "unexpected decode");
      end else begin
        n = q.pop_front();
        chk(cmd_result, n.res, "result");
        if (n.res == res_ok) chk(cmd_op, n.op, "op");
        if (n.op == op_proc_msg) chk(proc_msg_sel, n.sel, "selector");
        chk(global_reset_pulse, n.res == res_ok &&
          n.op == op_global_reset, "global pulse");
        chk(proc_reset_pulse, n.res == res_ok &&
          n.op inside {op_proc_reset, op_global_reset}, "proc pulse");
        if (n.ca) begin
          chk(arg_a, n.aa, "first field");
          chk(arg_b, n.ab, "second field");
          chk(arg_c, n.ac, "wide field");
        end
        check_cfg(n);
      end
    end
    cv_seen = (cmd_valid === 1'b1);
  end

  initial begin
    #60us;
    err_count++;
    close_out();
  end

  initial begin
    m = '{op_none, res_ok, 1'b1, 1'b0, '0, '0, {32{4'h3}}, 8'h00, 1'b0, 8'h00, 8'h00, 16'h0000};
    repeat (3) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    check_cfg(m);
    m.mu = 1'b0;
    send("SEA", op_companding, res_ok);
    send("SEX", op_companding, res_bad_param);
    m.mu = 1'b1;
    send("SEM", op_companding, res_ok);
    m.irq = 1'b1;
    send("IN", op_irq_on, res_ok);
    m.irq = 1'b0;
    send("IF", op_irq_off, res_ok);
    m.irq = 1'b1;
    send("IN", op_irq_on, res_ok);
    send("ZZ", op_none, res_bad_prefix);
    // random line power on the high bank
    s = "SFH";
    al = "FN*";
    for (int i = 0; i < 16; i++) begin
      c = al[rnd() % 3];
      s = {s, string'(c)};
      if (c != "*") m.lp[16 + i] = (c == "N");
    end
    send(s, op_line_power, res_ok, 1'b1, 8'h10);
    // port 0 network, port 1 terminal, the rest random
    s = "STLNT";
    al = "NTU*";
    m.role[3:0] = 4'h9;
    for (int i = 2; i < 16; i++) begin
      c = al[rnd() % 4];
      s = {s, string'(c)};
      if (c != "*") m.role[2 * i +: 2] = (c == "N") ? 2'd1 : (c == "T") ? 2'd2 : 2'd0;
    end
    send(s, op_port_role, res_ok);
    s = "SLH";
    al = "23ADEN";
    for (int i = 0; i < 16; i++) begin
      c = al[rnd() % 6];
      s = {s, string'(c)};
      m.prot[4 * (16 + i) +: 4] = (c == "N") ? 4'h5 : (c < "A") ? c[3:0] : c[3:0] + 4'h9;
    end
    send(s, op_protocol, res_ok);
    send("RI00", op_phy_deact, res_ok);
    send("RI01", op_phy_deact, res_bad_param);
    send("RL00", op_phy_react, res_ok);
    send("TR007F", op_id_remove, res_ok);
    send("TR017F", op_id_remove, res_bad_param);
    send("TF003F", op_fixed_id, res_ok, 1'b1, 8'h00, 8'h3f);
    send("TF0040", op_fixed_id, res_bad_param);
    send("TP007E", op_packet_id, res_ok);
    send("TP007F", op_packet_id, res_bad_param);
    // every tone code and the first one past it
    for (int y = 0; y < 13; y++) begin
      s = "CP05";
      s = {s, string'(byte'(y < 10 ? 8'h30 + y : 8'h37 + y))};
      send(s, op_tone, y < 12 ? res_ok : res_bad_param, 1'b1, 8'h05, 8'(y));
    end
    send("CS051F25", op_tone_slot, res_ok, 1'b1, 8'h05, 8'h25, 16'h1f25);
    send("CS052025", op_tone_slot, res_bad_param);
    send("CS051F80", op_tone_slot, res_bad_param);
    send("CT050123456789*#ABCDULXP", op_dial, res_ok);
    send("CT05E", op_dial, res_bad_param);
    s = "CT05";
    repeat (28) s = {s, "7"};
    send(s, op_dial, res_ok);
    send({s, "7"}, op_dial, res_bad_param);
    send({s.substr(0, 30), "E"}, op_dial, res_bad_param);
    m.sel = 8'h07;
    send("QP1G", op_proc_msg, res_ok, 1'b1, 8'h01, 8'h07);
    send("@1A2F", op_fw_load, res_ok, 1'b1, 8'h00, 8'h00, 16'h1a2f);
    send("@12G4", op_fw_load, res_bad_param);
    send("@E3", op_fw_erase, res_ok, 1'b1, 8'h03);
    send("@W3", op_fw_copy, res_ok);
    send("RD", op_proc_reset, res_ok);
    m.lp = '0;
    m.irq = 1'b0;
    send("RA", op_global_reset, res_ok);
    // frozen clock enable must ignore a stray character
    ce = 1'b0;
    char_valid = 1'b1;
    char_data = "Z";
    repeat (3) @(posedge clk_sys);
    #1;
    ce = 1'b1;
    m.mu = 1'b0;
    send("SEA", op_companding, res_ok);
    char_valid = 1'b0;
    repeat (8) @(posedge clk_sys);
    chk(q.size(), 0, "missing decodes");
    close_out();
  end
endmodule
